// file: rtl/uart_status_and_control.sv
// Serial port transmit/receive engine with status/control over AXI4-Lite.
// Operation
// - Without infrared coding, polarity bit set idles the line low, else high.
// - With infrared coding, the encoded line idles at the polarity bit level.
// - Break sends start, twelve zeros, stop; request bit then clears itself.
// - Transmit enable drives pin; clearing aborts, empties buffer, releases pin.
// - Buffer-full flag is one only when no further character fits.
// - All-empty flag is one only when shifter and buffer are empty.
// - Select 11 raises receive event when a transfer makes four characters.
// - Select 10 raises receive event when a transfer makes three characters.
// - Select 0x raises receive event on every character transferred in.
// - Address detect in 9-bit mode keeps only characters with bit 8 set.
// - Receiver idle flag is one while no character is being received.
// - Parity error flag describes the character at the receive buffer head.
// - Framing error flag describes the character at the receive buffer head.
// - Overrun flag sets on receive overflow; software only reads or clears it.
// - Clearing a set overrun flag empties receive buffer and shift register.
// - Data-available flag is one while the receive buffer is not empty.
// - Transmit event on load, on all shifted out, or on load leaving empty.
// - Format select gives 8N, 8 even, 8 odd or 9-bit data.
// - Infrared enable switches the encoder and decoder on the lines.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "uart_status_map.svh"
module uart_status_and_control #(
   parameter int FIFO_D = 4
)
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic [`AXI_ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [`AXI_ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic SERIAL_RX,
   output logic SERIAL_TX,
   output logic SERIAL_TX_OE,
   output logic TX_EVENT,
   output logic RX_EVENT
);
   import uart_pkg::*;
   localparam int CW = $clog2(FIFO_D + 1);
   logic txisel1_r, txinv_r, txisel0_r, brk_r, txen_r, address_detect_enable_r, infrared_codec_enable_r, ovr_r;
   logic [1:0] rxisel_r, pds_r;
   logic [15:0] div_r, status, ir_w;
   logic parity_error_flag_r, framing_error_flag_r;
   logic aw_got_r, w_got_r, wr_do, aw_take, w_take, ar_take;
   logic aw_hold_nxt, w_hold_nxt, bvalid_nxt, rvalid_nxt;
   logic [`AXI_ADDR_W-1:0] waddr_r;
   logic [31:0] wdata_r, rd_val;
   logic [3:0] wstrb_r;
   logic rd_hit, wr_hit, sw_sta, sw_fmt, sw_div, ovr_clr;
   tx_state_t tx_st_r;
   rx_state_t rx_st_r;
   logic [15:0] tx_cnt_r, rx_cnt_r;
   logic [3:0] tx_bit_r, rx_bit_r, tx_nbits, rx_nbits;
   logic [8:0] tx_shift_r, tx_head, rx_sh_r, rx_data;
   logic tx_par_r, tx_brk_r, tx_tick, tx_ld, tx_bit, ir_pulse, tx_line, tx_evt;
   logic brk_done, tx_push, par_en, pds9;
   logic [CW-1:0] tx_count, rx_count, rx_after;
   logic rx_tick, rx_half, rx_low_r, rx_low, rx_bit, rx_pbit_r, rx_done;
   logic rx_parity_error_flag, rx_keep, rx_push, rx_pop, rx_ovf, rx_evt;
   logic [10:0] rx_head;

   assign pds9 = pds_r == `PDS_9N;
   assign par_en = pds_r == `PDS_8E || pds_r == `PDS_8O;

   // Write address and data may arrive in either order.
   assign aw_take = AWVALID && AWREADY;
   assign w_take = WVALID && WREADY;
   assign ar_take = ARVALID && ARREADY;
   assign wr_do = aw_got_r && w_got_r;
   assign aw_hold_nxt = (aw_got_r || aw_take) && !wr_do;
   assign w_hold_nxt = (w_got_r || w_take) && !wr_do;
   assign bvalid_nxt = wr_do || (BVALID && !BREADY);
   assign rvalid_nxt = ar_take || (RVALID && !RREADY);
   assign sw_sta = wr_do && waddr_r == `OFS_STATUS;
   assign sw_fmt = wr_do && waddr_r == `OFS_FORMAT;
   assign sw_div = wr_do && waddr_r == `OFS_BAUDDIV;
   assign tx_push = wr_do && waddr_r == `OFS_TXDATA && wstrb_r[0] && txen_r;
   assign wr_hit = sw_sta || sw_fmt || sw_div || waddr_r == `OFS_TXDATA;

   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         aw_got_r <= 1'h0;
         w_got_r <= 1'h0;
         waddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         AWREADY <= 1'h0;
         WREADY <= 1'h0;
         BVALID <= 1'h0;
         BRESP <= `RESP_OKAY;
      end
      else
      begin
         aw_got_r <= aw_hold_nxt;
         w_got_r <= w_hold_nxt;
         if (aw_take)
            waddr_r <= AWADDR;
         if (w_take)
         begin
            wdata_r <= WDATA;
            wstrb_r <= WSTRB;
         end
         AWREADY <= !aw_hold_nxt && !bvalid_nxt;
         WREADY <= !w_hold_nxt && !bvalid_nxt;
         BVALID <= bvalid_nxt;
         if (wr_do)
            BRESP <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   // Reading the receive data register pops the buffer head.
   assign rx_pop = ar_take && ARADDR == `OFS_RXDATA;
   assign status = {txisel1_r, txinv_r, txisel0_r, 1'h0, brk_r, txen_r,
      tx_count == CW'(FIFO_D), tx_count == '0 && tx_st_r == TX_IDLE,
      rxisel_r, address_detect_enable_r, rx_st_r == RX_IDLE, parity_error_flag_r, framing_error_flag_r, ovr_r,
      rx_count != '0};

   always_comb
   begin
      rd_val = 32'h0;
      rd_hit = 1'h1;
      case (ARADDR)
         `OFS_STATUS: rd_val[15:0] = status;
         `OFS_FORMAT:
         begin
            rd_val[`FMT_INFRARED_CODEC_ENABLE] = infrared_codec_enable_r;
            rd_val[`FMT_PDS_HI:`FMT_PDS_LO] = pds_r;
         end
         `OFS_TXDATA: rd_val = 32'h0;
         `OFS_RXDATA: rd_val[8:0] = rx_head[8:0];
         `OFS_BAUDDIV: rd_val[15:0] = div_r;
         default: rd_hit = 1'h0;
      endcase
   end

   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         ARREADY <= 1'h0;
         RVALID <= 1'h0;
         RDATA <= 32'h0;
         RRESP <= `RESP_OKAY;
      end
      else
      begin
         ARREADY <= !rvalid_nxt;
         RVALID <= rvalid_nxt;
         if (ar_take)
         begin
            RDATA <= rd_val;
            RRESP <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Only a zero written while overrun is set clears it; a new overflow wins.
   assign ovr_clr = sw_sta && wstrb_r[0] && !wdata_r[`ST_OVERRUN_FLAG] && ovr_r
      && !rx_ovf;

   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         txisel1_r <= 1'h0;
         txinv_r <= 1'h0;
         txisel0_r <= 1'h0;
         brk_r <= 1'h0;
         txen_r <= 1'h0;
         rxisel_r <= 2'h0;
         address_detect_enable_r <= 1'h0;
         infrared_codec_enable_r <= 1'h0;
         pds_r <= `PDS_8N;
         div_r <= `BAUD_DIV_RST;
      end
      else
      begin
         if (sw_sta && wstrb_r[1])
         begin
            txisel1_r <= wdata_r[`ST_TXISEL1];
            txinv_r <= wdata_r[`ST_TXINV];
            txisel0_r <= wdata_r[`ST_TXISEL0];
            brk_r <= wdata_r[`ST_BRK];
            txen_r <= wdata_r[`ST_TXEN];
         end
         else if (brk_done)
            brk_r <= 1'h0;
         if (sw_sta && wstrb_r[0])
         begin
            rxisel_r <= wdata_r[`ST_RXISEL_HI:`ST_RXISEL_LO];
            address_detect_enable_r <= wdata_r[`ST_ADDRESS_DETECT_ENABLE];
         end
         if (sw_fmt && wstrb_r[1])
            infrared_codec_enable_r <= wdata_r[`FMT_INFRARED_CODEC_ENABLE];
         if (sw_fmt && wstrb_r[0])
            pds_r <= wdata_r[`FMT_PDS_HI:`FMT_PDS_LO];
         if (sw_div && wstrb_r[0])
            div_r[7:0] <= wdata_r[7:0];
         if (sw_div && wstrb_r[1])
            div_r[15:8] <= wdata_r[15:8];
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
         ovr_r <= 1'h0;
      else if (rx_ovf)
         ovr_r <= 1'h1;
      else if (ovr_clr)
         ovr_r <= 1'h0;
   end

   uart_fifo #(.W(9), .D(FIFO_D), .CW(CW)) tx_fifo (
      .clk(CLOCK),
      .rst(SYS_RST),
      .flush(!txen_r),
      .push(tx_push),
      .din(wdata_r[8:0]),
      .pop(tx_ld),
      .head(tx_head),
      .count(tx_count)
   );

   // Transmitter; a break is sent without consuming a buffered character.
   assign tx_tick = tx_cnt_r == div_r - 16'h0001;
   assign tx_ld = tx_st_r == TX_IDLE && txen_r && !brk_r && tx_count != '0;
   assign tx_nbits = tx_brk_r ? `BREAK_BITS
      : (pds9 ? `DATA9_BITS : `DATA8_BITS);
   assign brk_done = tx_st_r == TX_STOP && tx_tick && tx_brk_r;

   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         tx_st_r <= TX_IDLE;
         tx_cnt_r <= 16'h0;
         tx_bit_r <= 4'h0;
         tx_shift_r <= 9'h0;
         tx_par_r <= 1'h0;
         tx_brk_r <= 1'h0;
      end
      else if (!txen_r)
      begin
         tx_st_r <= TX_IDLE;
         tx_cnt_r <= 16'h0;
         tx_brk_r <= 1'h0;
      end
      else
      begin
         tx_cnt_r <= (tx_st_r == TX_IDLE || tx_tick) ? 16'h0
            : tx_cnt_r + 16'h0001;
         case (tx_st_r)
            TX_IDLE:
               if (brk_r)
               begin
                  tx_st_r <= TX_START;
                  tx_brk_r <= 1'h1;
               end
               else if (tx_ld)
               begin
                  tx_st_r <= TX_START;
                  tx_shift_r <= tx_head;
                  tx_par_r <= (^tx_head[7:0]) ^ (pds_r == `PDS_8O);
               end
            TX_START:
               if (tx_tick)
               begin
                  tx_st_r <= TX_DATA;
                  tx_bit_r <= 4'h0;
               end
            TX_DATA:
               if (tx_tick)
               begin
                  tx_shift_r <= {1'h0, tx_shift_r[8:1]};
                  tx_bit_r <= tx_bit_r + 4'h1;
                  if (tx_bit_r == tx_nbits - 4'h1)
                     tx_st_r <= (par_en && !tx_brk_r) ? TX_PARITY : TX_STOP;
               end
            TX_PARITY:
               if (tx_tick)
                  tx_st_r <= TX_STOP;
            TX_STOP:
               if (tx_tick)
               begin
                  tx_st_r <= TX_IDLE;
                  tx_brk_r <= 1'h0;
               end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   always_comb
   begin
      case (tx_st_r)
         TX_START: tx_bit = 1'h0;
         TX_DATA: tx_bit = tx_shift_r[0] && !tx_brk_r;
         TX_PARITY: tx_bit = tx_par_r;
         default: tx_bit = 1'h1;
      endcase
   end

   // Infrared zero bits are a pulse three sixteenths of a bit long.
   assign ir_w = {3'h0, div_r[15:3]} + {4'h0, div_r[15:4]};
   assign ir_pulse = !tx_bit && tx_cnt_r < ir_w;
   assign tx_line = infrared_codec_enable_r ? (txinv_r ^ ir_pulse)
      : (txinv_r ^ tx_bit);

   always_comb
   begin
      case ({txisel1_r, txisel0_r})
         `TXI_LOAD: tx_evt = tx_ld;
         `TXI_DONE: tx_evt = tx_st_r == TX_STOP && tx_tick && txen_r
            && tx_count == '0;
         `TXI_EMPTY: tx_evt = tx_ld && tx_count == CW'(1);
         default: tx_evt = 1'h0;
      endcase
   end

   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         SERIAL_TX <= 1'h1;
         SERIAL_TX_OE <= 1'h0;
         TX_EVENT <= 1'h0;
      end
      else
      begin
         SERIAL_TX <= tx_line;
         SERIAL_TX_OE <= txen_r;
         TX_EVENT <= tx_evt;
      end
   end

   // Receiver; in infrared mode any low pulse inside a bit reads as zero.
   assign rx_tick = rx_cnt_r == div_r - 16'h0001;
   assign rx_half = rx_cnt_r == {1'h0, div_r[15:1]};
   assign rx_low = rx_low_r || !SERIAL_RX;
   assign rx_bit = infrared_codec_enable_r ? !rx_low : SERIAL_RX;
   assign rx_nbits = pds9 ? `DATA9_BITS : `DATA8_BITS;
   assign rx_data = pds9 ? rx_sh_r : {1'h0, rx_sh_r[8:1]};
   assign rx_done = rx_st_r == RX_STOP && rx_tick;
   assign rx_parity_error_flag = par_en
      && (rx_pbit_r != ((^rx_data[7:0]) ^ (pds_r == `PDS_8O)));
   assign rx_keep = !(address_detect_enable_r && pds9 && !rx_data[8]);
   assign rx_push = rx_done && rx_keep && !ovr_r && rx_count != CW'(FIFO_D);
   assign rx_ovf = rx_done && rx_keep && rx_count == CW'(FIFO_D);

   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         rx_st_r <= RX_IDLE;
         rx_cnt_r <= 16'h0;
         rx_low_r <= 1'h0;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 9'h0;
         rx_pbit_r <= 1'h0;
      end
      else if (ovr_clr)
      begin
         rx_st_r <= RX_IDLE;
         rx_cnt_r <= 16'h0;
         rx_low_r <= 1'h0;
      end
      else
      begin
         rx_cnt_r <= rx_tick ? 16'h0 : rx_cnt_r + 16'h0001;
         rx_low_r <= rx_tick ? 1'h0 : rx_low;
         case (rx_st_r)
            RX_IDLE:
            begin
               rx_cnt_r <= 16'h0;
               rx_low_r <= 1'h0;
               if (!SERIAL_RX)
                  rx_st_r <= RX_START;
            end
            RX_START:
               if (rx_half)
               begin
                  rx_cnt_r <= 16'h0;
                  rx_low_r <= 1'h0;
                  rx_bit_r <= 4'h0;
                  rx_st_r <= (infrared_codec_enable_r || !SERIAL_RX) ? RX_DATA : RX_IDLE;
               end
            RX_DATA:
               if (rx_tick)
               begin
                  rx_sh_r <= {rx_bit, rx_sh_r[8:1]};
                  rx_bit_r <= rx_bit_r + 4'h1;
                  if (rx_bit_r == rx_nbits - 4'h1)
                     rx_st_r <= par_en ? RX_PARITY : RX_STOP;
               end
            RX_PARITY:
               if (rx_tick)
               begin
                  rx_pbit_r <= rx_bit;
                  rx_st_r <= RX_STOP;
               end
            RX_STOP:
               if (rx_tick)
                  rx_st_r <= RX_IDLE;
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   uart_fifo #(.W(11), .D(FIFO_D), .CW(CW)) rx_fifo (
      .clk(CLOCK),
      .rst(SYS_RST),
      .flush(ovr_clr),
      .push(rx_push),
      .din({!rx_bit, rx_parity_error_flag, rx_data}),
      .pop(rx_pop),
      .head(rx_head),
      .count(rx_count)
   );

   assign rx_after = rx_count + CW'(1);
   always_comb
   begin
      if (!rxisel_r[1])
         rx_evt = rx_push;
      else if (rxisel_r == `RXI_FULL)
         rx_evt = rx_push && rx_after == CW'(`RX_LVL_FULL);
      else
         rx_evt = rx_push && rx_after == CW'(`RX_LVL_3Q);
   end

   // Flags follow the head so they always describe the next read.
   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         parity_error_flag_r <= 1'h0;
         framing_error_flag_r <= 1'h0;
         RX_EVENT <= 1'h0;
      end
      else
      begin
         parity_error_flag_r <= rx_count != '0 && rx_head[`RXE_PARITY_ERROR_FLAG];
         framing_error_flag_r <= rx_count != '0 && rx_head[`RXE_FRAMING_ERROR_FLAG];
         RX_EVENT <= rx_evt;
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   sequence s_ovr_clear;
      ovr_clr ##1 1'h1;
   endsequence
   a_idle_plain_level: assert property (
      tx_st_r == TX_IDLE && !infrared_codec_enable_r |=> SERIAL_TX == !$past(txinv_r))
      else $error("plain idle level wrong");
   a_idle_ir_level: assert property (
      tx_st_r == TX_IDLE && infrared_codec_enable_r |=> SERIAL_TX == $past(txinv_r))
      else $error("infrared idle level wrong");
   a_break_self_clear: assert property (
      brk_done && !(sw_sta && wstrb_r[1]) |=> !brk_r)
      else $error("break request not cleared");
   a_tx_abort: assert property (
      !txen_r |=> tx_st_r == TX_IDLE && tx_count == '0 && !SERIAL_TX_OE)
      else $error("transmit not aborted");
   a_status_txbf: assert property (
      ar_take && ARADDR == `OFS_STATUS |=>
      RDATA[9] == $past(tx_count == CW'(FIFO_D)))
      else $error("buffer full flag wrong");
   a_status_tx_all_empty: assert property (
      ar_take && ARADDR == `OFS_STATUS |=>
      RDATA[8] == $past(tx_count == '0 && tx_st_r == TX_IDLE))
      else $error("all empty flag wrong");
   a_rx_full_event: assert property (
      rx_push && rxisel_r == `RXI_FULL && rx_after == CW'(`RX_LVL_FULL)
      |=> RX_EVENT) else $error("full event missing");
   a_rx_event_cause: assert property (
      RX_EVENT |-> $past(rx_push)) else $error("event without transfer");
   a_overrun_set: assert property (
      rx_ovf |=> ovr_r) else $error("overrun not set");
   a_overrun_flush: assert property (
      s_ovr_clear |-> rx_count == '0 && rx_st_r == RX_IDLE && !ovr_r)
      else $error("overrun clear did not flush");
   a_head_parity_error_flag: assert property (
      rx_count != '0 |=> parity_error_flag_r == $past(rx_head[`RXE_PARITY_ERROR_FLAG]))
      else $error("parity flag not from head");
endmodule

// file: rtl/uart_status_map.svh
// Register offsets, field positions, codes and reset values of the serial port.
`ifndef UART_STATUS_MAP_SVH
`define UART_STATUS_MAP_SVH
`define AXI_ADDR_W 8
`define OFS_STATUS 8'h00
`define OFS_FORMAT 8'h04
`define OFS_TXDATA 8'h08
`define OFS_RXDATA 8'h0C
`define OFS_BAUDDIV 8'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ST_TXISEL1 15
`define ST_TXINV 14
`define ST_TXISEL0 13
`define ST_BRK 11
`define ST_TXEN 10
`define ST_RXISEL_HI 7
`define ST_RXISEL_LO 6
`define ST_ADDRESS_DETECT_ENABLE 5
`define ST_OVERRUN_FLAG 1
`define FMT_INFRARED_CODEC_ENABLE 12
`define FMT_PDS_HI 2
`define FMT_PDS_LO 1
`define RXE_PARITY_ERROR_FLAG 9
`define RXE_FRAMING_ERROR_FLAG 10
`define PDS_8N 2'h0
`define PDS_8E 2'h1
`define PDS_8O 2'h2
`define PDS_9N 2'h3
`define TXI_LOAD 2'h0
`define TXI_DONE 2'h1
`define TXI_EMPTY 2'h2
`define RXI_FULL 2'h3
`define RX_LVL_3Q 4'h3
`define RX_LVL_FULL 4'h4
`define BREAK_BITS 4'hC
`define DATA9_BITS 4'h9
`define DATA8_BITS 4'h8
`define BAUD_DIV_RST 16'h0364
`endif

// file: rtl/uart_pkg.sv
// State types shared by the serial port block.
package uart_pkg;
   typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
      TX_PARITY = 3'h2, TX_STOP = 3'h6} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
      RX_PARITY = 3'h2, RX_STOP = 3'h6} rx_state_t;
endpackage

// file: rtl/uart_fifo.sv
// Small synchronous FIFO used for the transmit and receive buffers.
`timescale 1ns/1ps
module uart_fifo #(
   parameter int W = 9,
   parameter int D = 4,
   parameter int CW = $clog2(D + 1)
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic push,
   input wire logic [W-1:0] din,
   input wire logic pop,
   output logic [W-1:0] head,
   output logic [CW-1:0] count
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_r, rp_r;
   logic do_push, do_pop;

   // A push into a full buffer is dropped; the receive caller flags the loss, the transmit caller does not.
   assign do_push = push && count != CW'(D);
   assign do_pop = pop && count != '0;
   assign head = mem[rp_r];

   always_ff @(posedge clk)
   begin
      if (do_push)
         mem[wp_r] <= din;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         count <= '0;
      end
      else if (flush)
      begin
         wp_r <= '0;
         rp_r <= '0;
         count <= '0;
      end
      else
      begin
         if (do_push)
            wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + AW'(1);
         if (do_pop)
            rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + AW'(1);
         count <= count + CW'(do_push) - CW'(do_pop);
      end
   end

   a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
      count <= CW'(D)) else $error("fifo count above depth");
   a_fifo_flush: assert property (@(posedge clk) disable iff (rst)
      flush |=> count == '0) else $error("fifo not empty after flush");
endmodule

// file: testbench/serial_node.sv
// Remote serial node: drives the receive line and times the transmit line.
`timescale 1ns/1ps
module serial_node #(
   parameter int DIV = 16
)
(
   input wire logic clk,
   input wire logic tx_line,
   output logic rx_line
);
   // The node drives the line high at start and after each frame, so between frames it rests high.
   initial rx_line = 1'b1;
   task automatic send(input logic [9:0] b, input int n, input logic stp);
      rx_line <= 1'b0;
      repeat (DIV) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         rx_line <= b[i];
         repeat (DIV) @(posedge clk);
      end
      rx_line <= stp;
      repeat (DIV) @(posedge clk);
      rx_line <= 1'b1;
      repeat (DIV) @(posedge clk);
   endtask
   task automatic low_len(output int n);
      n = 0;
      while (tx_line !== 1'b0) @(posedge clk);
      while (tx_line === 1'b0)
      begin
         n++;
         @(posedge clk);
      end
   endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the serial port status and control block.
`timescale 1ns/1ps
`include "uart_status_map.svh"
module tb;
   logic CLOCK, SYS_RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, d;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP, r;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SRX, STX, OE, TXE, RXE;
   int n_fail, cmp_count, n_ev, n_tx, n;
   uart_status_and_control dut_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
      .RVALID(RVALID), .RREADY(RREADY), .SERIAL_RX(SRX), .SERIAL_TX(STX),
      .SERIAL_TX_OE(OE), .TX_EVENT(TXE), .RX_EVENT(RXE));
   serial_node #(.DIV(16)) node_u (.clk(CLOCK), .tx_line(STX),
      .rx_line(SRX));
   initial
   begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) if (RXE === 1'b1) n_ev++;
   always @(posedge CLOCK) if (TXE === 1'b1) n_tx++;
   task automatic chk(input string s, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CLOCK);
      AWADDR <= a;
      WDATA <= v;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do
      begin
         @(posedge CLOCK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         if (BVALID) BREADY <= 1'b0;
      end
      while (!BVALID);
      // Pins launched at the response edge are only settled one edge later.
      @(posedge CLOCK);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge CLOCK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do
      begin
         @(posedge CLOCK);
         if (ARREADY) ARVALID <= 1'b0;
      end
      while (!RVALID);
      RREADY <= 1'b0;
      d = RDATA;
      r = RRESP;
   endtask
   task automatic st(input logic [31:0] e);
      rd(`OFS_STATUS);
      chk("status", e, d);
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #500000;
      n_fail++;
      print_verdict();
   end
   initial
   begin
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
      {AWADDR, ARADDR, WDATA} = '0;
      WSTRB = 4'hF;
      n_fail = 0;
      cmp_count = 0;
      n_ev = 0;
      n_tx = 0;
      SYS_RST = 1'b1;
      repeat (3) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      st(32'h00000110);
      rd(8'h14);
      chk("resp", `RESP_SLVERR, r);
      wr(`OFS_BAUDDIV, 32'h00000010);
      wr(`OFS_STATUS, 32'h00000400);
      chk("idle", 1'b1, STX);
      chk("oe", 1'b1, OE);
      wr(`OFS_STATUS, 32'h00004400);
      chk("idle", 1'b0, STX);
      wr(`OFS_FORMAT, 32'h00001000);
      chk("ir idle", 1'b1, STX);
      wr(`OFS_STATUS, 32'h00000400);
      chk("ir idle", 1'b0, STX);
      wr(`OFS_FORMAT, 32'h00000000);
      wr(`OFS_STATUS, 32'h00000C00);
      node_u.low_len(n);
      chk("break", 13 * 16, n);
      repeat (20) @(posedge CLOCK);
      st(32'h00000510);
      repeat (5) wr(`OFS_TXDATA, 32'h000000A5);
      st(32'h00000610);
      chk("tx events", 1, n_tx);
      wr(`OFS_STATUS, 32'h00000000);
      st(32'h00000110);
      chk("oe", 1'b0, OE);
      wr(`OFS_FORMAT, 32'h00000002);
      wr(`OFS_STATUS, 32'h000004C0);
      for (int i = 0; i < 5; i++)
      begin
         node_u.send({^i[7:0], i[7:0]}, 9, 1'b1);
         if (i == 3) chk("events", 1, n_ev);
      end
      st(32'h000005D3);
      wr(`OFS_STATUS, 32'h000004C0);
      st(32'h000005D0);
      n_ev = 0;
      wr(`OFS_STATUS, 32'h00000400);
      node_u.send({1'b0, 8'h01}, 9, 1'b1);
      node_u.send({1'b1, 8'h01}, 9, 1'b0);
      chk("events", 2, n_ev);
      st(32'h00000519);
      rd(`OFS_RXDATA);
      chk("rxdata", 32'h00000001, d);
      st(32'h00000515);
      wr(`OFS_FORMAT, 32'h00000006);
      wr(`OFS_STATUS, 32'h000004A0);
      n_ev = 0;
      node_u.send({1'b0, 8'h5A}, 9, 1'b1);
      node_u.send({1'b1, 8'hA5}, 9, 1'b1);
      node_u.send({1'b1, 8'h3C}, 9, 1'b1);
      chk("events", 1, n_ev);
      st(32'h000005B5);
      rd(`OFS_RXDATA);
      rd(`OFS_RXDATA);
      chk("rxdata", 32'h000001A5, d);
      print_verdict();
   end
endmodule
